// ==== inc/sptpc_pkg.sv ====
// Shared constants, register numbers and carrier types for the serial port control block.
package sptpc_pkg;

  // ==========================================================================
  // Register numbers (the register port carries the register number itself)
  localparam logic [15:0] SPTPC_REG_PORT_SEL = 16'h2EE0;
  localparam logic [15:0] SPTPC_REG_RX_STATUS = 16'h300E;
  localparam logic [15:0] SPTPC_REG_PARSE_EN = 16'h300F;
  localparam logic [15:0] SPTPC_REG_DONE_LEN = 16'h3019;
  localparam logic [15:0] SPTPC_REG_MSG_XFER = 16'h301C;
  localparam logic [15:0] SPTPC_REG_PROTOCOL = 16'h3020;
  localparam logic [15:0] SPTPC_REG_ACT_ADDR = 16'h3021;
  localparam logic [15:0] SPTPC_REG_GLB_ADDR = 16'h3022;
  localparam logic [15:0] SPTPC_REG_SWAP = 16'h3023;
  localparam logic [15:0] SPTPC_REG_TERM_CHAR = 16'h3070;
  localparam logic [15:0] SPTPC_REG_SAVE = 16'h4E80;

  // ==========================================================================
  // Reset values and field values
  localparam logic [7:0] SPTPC_TERM_RESET = 8'h0D;
  localparam logic [7:0] SPTPC_RX_DONE_MARK = 8'hFF;
  localparam logic [31:0] SPTPC_SAVE_CMD = 32'h0000_0001;
  localparam logic [31:0] SPTPC_MSG_OK = 32'h0000_0000;
  localparam logic [7:0] SPTPC_PORT_SEL_RESET = 8'h00;

  // ==========================================================================
  // Block transfer limits, in registers
  localparam logic [8:0] SPTPC_RTU_MAX16 = 9'd120;
  localparam logic [8:0] SPTPC_RTU_MAX32 = 9'd60;
  localparam logic [8:0] SPTPC_ASC_MAX16 = 9'd56;
  localparam logic [8:0] SPTPC_ASC_MAX32 = 9'd28;
  localparam logic [8:0] SPTPC_DEBLOCK_MAX = 9'd256;

  // ==========================================================================
  // Protocol codes
  typedef enum logic [2:0] {
    SPTPC_PROTO_NATIVE = 3'b000,
    SPTPC_PROTO_MST_RTU = 3'b001,
    SPTPC_PROTO_MST_ASC = 3'b010,
    SPTPC_PROTO_SLV_RTU = 3'b011,
    SPTPC_PROTO_SLV_ASC = 3'b100,
    SPTPC_PROTO_DIAG = 3'b111
  } sptpc_proto_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] num;
    logic [31:0] wdata;
  } sptpc_reg_req_t;

  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } sptpc_reg_rsp_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [31:0] data;
  } sptpc_word_t;

  typedef struct packed {
    logic [8:0] max16;
    logic [8:0] max32;
    logic [8:0] total;
  } sptpc_limits_t;

endpackage

// ==== hdl/sptpc_rx_term.sv ====
// Terminator detection and buffer length counting for the receive path.
`timescale 1ns/1ps
`default_nettype none
module sptpc_rx_term #(
  parameter int LEN_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Received characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // Control
  input wire logic parse_en,
  input wire logic [7:0] term_char,
  input wire logic clear,
  // Results
  output logic hit,
  output logic [LEN_W-1:0] cur_len,
  output logic [LEN_W-1:0] done_len
);

  logic term_seen;

  // ==========================================================================
  // Compare only while parsing is off.
  assign term_seen = rx_valid && !parse_en && (rx_char == term_char); // RL4

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= term_seen; // RL1
    end
  end

  // A terminator in the same cycle as a clear wins, so no completed buffer is lost.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_len <= '0;
      done_len <= '0;
    end else if (term_seen) begin
      done_len <= cur_len + LEN_W'(1); // RL1
      cur_len <= '0;
    end else if (clear) begin
      done_len <= '0; // RL2
      cur_len <= '0;
    end else if (parse_en) begin
      cur_len <= '0; // RL4
    end else if (rx_valid) begin
      cur_len <= cur_len + LEN_W'(1); // RL14
    end
  end

endmodule
`default_nettype wire

// ==== hdl/sptpc_swap.sv ====
// Half-word exchange for Modbus reads of 32-bit registers.
`timescale 1ns/1ps
`default_nettype none
module sptpc_swap (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic swap_en,
  // Read data in and out
  input wire sptpc_pkg::sptpc_word_t rd_in,
  output sptpc_pkg::sptpc_word_t rd_out
);
  import sptpc_pkg::*;

  // ==========================================================================
  // Only even-boundary addresses start a 32-bit register; odd ones pass as is.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_out <= '0;
    end else begin
      rd_out.valid <= rd_in.valid;
      rd_out.addr <= rd_in.addr;
      if (rd_in.valid && swap_en && !rd_in.addr[0]) begin
        rd_out.data <= {rd_in.data[15:0], rd_in.data[31:16]}; // RL12
      end else begin
        rd_out.data <= rd_in.data;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/sptpc_top.sv ====
// Serial port terminator detection, protocol selection and addressing control.
// Functional notes
// RL1 - Terminator with parsing off: status gets 255, counter gets length incl. terminator.
// RL2 - Host writing zero to receive status also clears the completion counter.
// RL3 - Terminator register resets to carriage return, takes any 8-bit value.
// RL4 - Compare last character only with parsing off; counter idle otherwise.
// RL5 - Protocol resets to 0; codes 0,1,2,3,4,7 select native/master/slave/diagnostic.
// RL6 - Protocol write takes effect at once; host writes it after other settings.
// RL7 - Slave RTU serves at most 120 16-bit or 60 32-bit registers per block.
// RL8 - Slave ASCII serves at most 56 16-bit or 28 32-bit registers per block.
// RL9 - Master RTU reads 120, master ASCII 56 per block; de-blocking 256 total.
// RL10 - Active address follows global unless host overrides; only slave modes use it.
// RL11 - Global address loads at power-up; saved only after writing 1 to save register.
// RL12 - Swap control 1 exchanges halves on even-boundary 32-bit Modbus reads; resets 0.
// RL13 - Writing a record number sends that message; reads return status, 0 is success.
// RL14 - With parsing off every received character counts toward buffer length; a host clear zeroes the running count, a character in that cycle included.
`timescale 1ns/1ps
`default_nettype none
module sptpc_top #(
  parameter int LEN_W = 32,
  parameter logic [7:0] ADDR_DEFAULT = 8'h01
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire sptpc_pkg::sptpc_reg_req_t reg_req,
  output sptpc_pkg::sptpc_reg_rsp_t reg_rsp,
  // Received character stream from the serial receiver
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  // Modbus read path of 32-bit registers
  input wire sptpc_pkg::sptpc_word_t mb_rd_in,
  output sptpc_pkg::sptpc_word_t mb_rd_out,
  // Protocol and addressing state toward the protocol engines
  output sptpc_pkg::sptpc_proto_t proto,
  output logic [7:0] port_sel,
  output logic slave_addr_en,
  output logic [7:0] slave_addr,
  output sptpc_pkg::sptpc_limits_t limits,
  output logic term_hit,
  // Stored message sender
  output logic msg_send,
  output logic [31:0] msg_record,
  input wire logic msg_done,
  input wire logic [31:0] msg_status,
  // Nonvolatile storage of the global address
  input wire logic [7:0] nv_addr,
  input wire logic nv_addr_ok,
  output logic nv_save,
  output logic [7:0] nv_save_addr
);
  import sptpc_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic sptpc_limits_t limits_of(input sptpc_proto_t p);
    sptpc_limits_t l;
    l = '0;
    case (p)
      SPTPC_PROTO_SLV_RTU: begin
        l.max16 = SPTPC_RTU_MAX16; // RL7
        l.max32 = SPTPC_RTU_MAX32;
        l.total = SPTPC_RTU_MAX16;
      end
      SPTPC_PROTO_SLV_ASC: begin
        l.max16 = SPTPC_ASC_MAX16; // RL8
        l.max32 = SPTPC_ASC_MAX32;
        l.total = SPTPC_ASC_MAX16;
      end
      SPTPC_PROTO_MST_RTU: begin
        l.max16 = SPTPC_RTU_MAX16; // RL9
        l.total = SPTPC_DEBLOCK_MAX;
      end
      SPTPC_PROTO_MST_ASC: begin
        l.max16 = SPTPC_ASC_MAX16; // RL9
        l.total = SPTPC_DEBLOCK_MAX;
      end
      default: begin
        l = '0;
      end
    endcase
    return l;
  endfunction

  function automatic logic is_slave(input sptpc_proto_t p);
    return (p == SPTPC_PROTO_SLV_RTU) || (p == SPTPC_PROTO_SLV_ASC);
  endfunction

  function automatic logic proto_legal(input logic [2:0] code);
    case (code)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic hits(input sptpc_reg_req_t r, input logic [15:0] num);
    return r.wr && (r.num == num);
  endfunction

  // ==========================================================================
  // Registers
  logic [7:0] rx_status;
  logic parse_en;
  logic [7:0] term_char;
  logic swap_en;
  logic addr_override;
  logic [7:0] active_addr;
  logic [7:0] global_addr;
  logic [31:0] msg_stat;
  logic boot_load;
  logic rx_clear;
  logic hit;
  logic [LEN_W-1:0] cur_len;
  logic [LEN_W-1:0] done_len;
  logic [31:0] next_rdata;

  // ==========================================================================
  // Receive terminator and length
  assign rx_clear = hits(reg_req, SPTPC_REG_RX_STATUS) && (reg_req.wdata == 32'h0000_0000);

  sptpc_rx_term #(
    .LEN_W(LEN_W)
  ) u_rx_term (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rx_valid(rx_valid),
    .rx_char(rx_char),
    .parse_en(parse_en),
    .term_char(term_char),
    .clear(rx_clear),
    .hit(hit),
    .cur_len(cur_len),
    .done_len(done_len)
  );

  // The mark follows the counter by one cycle; a host write in that cycle loses to it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_status <= 8'h00;
      term_hit <= 1'b0;
    end else begin
      term_hit <= hit;
      if (hit) begin
        rx_status <= SPTPC_RX_DONE_MARK; // RL1
      end else if (hits(reg_req, SPTPC_REG_RX_STATUS)) begin
        rx_status <= reg_req.wdata[7:0]; // RL2
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      parse_en <= 1'b0;
      port_sel <= SPTPC_PORT_SEL_RESET;
    end else begin
      if (hits(reg_req, SPTPC_REG_PARSE_EN)) begin
        parse_en <= reg_req.wdata[0];
      end
      if (hits(reg_req, SPTPC_REG_PORT_SEL)) begin
        port_sel <= reg_req.wdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      term_char <= SPTPC_TERM_RESET; // RL3
    end else if (hits(reg_req, SPTPC_REG_TERM_CHAR)) begin
      term_char <= reg_req.wdata[7:0]; // RL3
    end
  end

  // ==========================================================================
  // Protocol select: an unknown code is ignored so the port never runs undefined.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      proto <= SPTPC_PROTO_NATIVE; // RL5
    end else if (hits(reg_req, SPTPC_REG_PROTOCOL) && proto_legal(reg_req.wdata[2:0])
                 && (reg_req.wdata[31:3] == 29'h0)) begin
      proto <= sptpc_proto_t'(reg_req.wdata[2:0]); // RL6
    end
  end

  // Limits track the live protocol register, so they change one cycle after it does.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      limits <= '0;
    end else begin
      limits <= limits_of(proto); // RL7
    end
  end

  // ==========================================================================
  // Addressing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_load <= 1'b1;
    end else if (nv_addr_ok) begin
      boot_load <= 1'b0;
    end
  end

  // The stored address is caught on the first clock edge after reset with nv_addr_ok high, not by the reset itself.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_addr <= ADDR_DEFAULT;
    end else if (hits(reg_req, SPTPC_REG_GLB_ADDR)) begin
      global_addr <= reg_req.wdata[7:0];
    end else if (boot_load && nv_addr_ok) begin
      global_addr <= nv_addr; // RL11
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_override <= 1'b0;
      active_addr <= ADDR_DEFAULT;
    end else if (hits(reg_req, SPTPC_REG_ACT_ADDR)) begin
      addr_override <= 1'b1;
      active_addr <= reg_req.wdata[7:0]; // RL10
    end else if (!addr_override) begin
      active_addr <= global_addr; // RL10
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_addr_en <= 1'b0;
      slave_addr <= 8'h00;
    end else begin
      slave_addr_en <= is_slave(proto); // RL10
      slave_addr <= active_addr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_save <= 1'b0;
      nv_save_addr <= 8'h00;
    end else begin
      nv_save <= hits(reg_req, SPTPC_REG_SAVE) && (reg_req.wdata == SPTPC_SAVE_CMD); // RL11
      nv_save_addr <= global_addr;
    end
  end

  // ==========================================================================
  // Endian swap and Modbus read path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      swap_en <= 1'b0; // RL12
    end else if (hits(reg_req, SPTPC_REG_SWAP)) begin
      swap_en <= reg_req.wdata[0];
    end
  end

  sptpc_swap u_swap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .swap_en(swap_en),
    .rd_in(mb_rd_in),
    .rd_out(mb_rd_out)
  );

  // ==========================================================================
  // Stored message transfer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_send <= 1'b0;
      msg_record <= 32'h0000_0000;
      msg_stat <= SPTPC_MSG_OK;
    end else begin
      msg_send <= hits(reg_req, SPTPC_REG_MSG_XFER); // RL13
      if (hits(reg_req, SPTPC_REG_MSG_XFER)) begin
        msg_record <= reg_req.wdata;
      end
      if (msg_done) begin
        msg_stat <= msg_status; // RL13
      end
    end
  end

  // ==========================================================================
  // Register reads: one cycle after the request, unknown numbers read zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_req.num)
      SPTPC_REG_PORT_SEL: next_rdata = {24'h0, port_sel};
      SPTPC_REG_RX_STATUS: next_rdata = {24'h0, rx_status};
      SPTPC_REG_PARSE_EN: next_rdata = {31'h0, parse_en};
      SPTPC_REG_DONE_LEN: next_rdata = 32'(done_len);
      SPTPC_REG_MSG_XFER: next_rdata = msg_stat; // RL13
      SPTPC_REG_PROTOCOL: next_rdata = {29'h0, proto};
      SPTPC_REG_ACT_ADDR: next_rdata = {24'h0, active_addr};
      SPTPC_REG_GLB_ADDR: next_rdata = {24'h0, global_addr};
      SPTPC_REG_SWAP: next_rdata = {31'h0, swap_en};
      SPTPC_REG_TERM_CHAR: next_rdata = {24'h0, term_char};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rsp <= '0;
    end else begin
      reg_rsp.rvalid <= reg_req.rd;
      reg_rsp.rdata <= reg_req.rd ? next_rdata : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ==== tb/sptpc_checker.sv ====
// Concurrent checks on the ports of the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module sptpc_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire sptpc_pkg::sptpc_reg_req_t reg_req,
  input wire logic rx_valid,
  input wire sptpc_pkg::sptpc_word_t mb_rd_in,
  input wire sptpc_pkg::sptpc_word_t mb_rd_out,
  input wire sptpc_pkg::sptpc_proto_t proto,
  input wire logic slave_addr_en,
  input wire sptpc_pkg::sptpc_limits_t limits,
  input wire logic term_hit,
  input wire logic msg_send,
  input wire logic [31:0] msg_record,
  input wire logic nv_save
);
  import sptpc_pkg::*;
  logic swap_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Mirror of the swap control, so the read path is judged from the ports alone.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      swap_q <= 1'b0;
    end else if (reg_req.wr && reg_req.num == SPTPC_REG_SWAP) begin
      swap_q <= reg_req.wdata[0];
    end
  end
  sequence s_proto_wr;
    reg_req.wr && reg_req.num == SPTPC_REG_PROTOCOL && reg_req.wdata[31:3] == '0
      && reg_req.wdata[2:0] != 3'h5 && reg_req.wdata[2:0] != 3'h6;
  endsequence
  sequence s_save_wr;
    reg_req.wr && reg_req.num == SPTPC_REG_SAVE && reg_req.wdata == SPTPC_SAVE_CMD;
  endsequence
  // ==========================================================================
  // Assertions
  chk_proto_legal: assert property (
    proto != 3'h5 && proto != 3'h6) else $error("Protocol code outside the legal set.");
  chk_proto_write_now: assert property (
    s_proto_wr |=> proto == $past(reg_req.wdata[2:0])) else $error("Protocol write late.");
  chk_slave_addr_use: assert property (
    slave_addr_en == ($past(proto) == SPTPC_PROTO_SLV_RTU || $past(proto) == SPTPC_PROTO_SLV_ASC))
    else $error("Slave address enable does not follow the protocol.");
  chk_limits_slave_rtu: assert property (
    $past(proto) == SPTPC_PROTO_SLV_RTU |-> limits == {SPTPC_RTU_MAX16, SPTPC_RTU_MAX32,
    SPTPC_RTU_MAX16}) else $error("Slave RTU limits wrong.");
  chk_limits_slave_asc: assert property (
    $past(proto) == SPTPC_PROTO_SLV_ASC |-> limits == {SPTPC_ASC_MAX16, SPTPC_ASC_MAX32,
    SPTPC_ASC_MAX16}) else $error("Slave ASCII limits wrong.");
  chk_limits_master: assert property (
    $past(proto) == SPTPC_PROTO_MST_RTU || $past(proto) == SPTPC_PROTO_MST_ASC |->
    limits.total == SPTPC_DEBLOCK_MAX && limits.max16 == ($past(proto) == SPTPC_PROTO_MST_RTU ?
    SPTPC_RTU_MAX16 : SPTPC_ASC_MAX16)) else $error("Master limits wrong.");
  chk_term_hit_cause: assert property (
    term_hit |-> $past(rx_valid, 2)) else $error("Terminator flag without a character.");
  chk_swap_halves: assert property (
    mb_rd_out.valid |-> $past(mb_rd_in.valid) && mb_rd_out.data == (($past(swap_q)
    && !$past(mb_rd_in.addr[0])) ? {$past(mb_rd_in.data[15:0]), $past(mb_rd_in.data[31:16])}
    : $past(mb_rd_in.data))) else $error("Read path data wrong.");
  chk_msg_send_now: assert property (
    reg_req.wr && reg_req.num == SPTPC_REG_MSG_XFER |=> msg_send
    && msg_record == $past(reg_req.wdata)) else $error("Message send missing.");
  chk_nv_save_pulse: assert property (
    s_save_wr |=> nv_save) else $error("Save request missing.");
endmodule
bind sptpc_top sptpc_checker u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
  .rx_valid(rx_valid), .mb_rd_in(mb_rd_in), .mb_rd_out(mb_rd_out), .proto(proto),
  .slave_addr_en(slave_addr_en), .limits(limits), .term_hit(term_hit), .msg_send(msg_send),
  .msg_record(msg_record), .nv_save(nv_save));
`default_nettype wire

// ==== tb/sptpc_peer.sv ====
// Serial peer and stored message sender that face the block.
`timescale 1ns/1ps
`default_nettype none
module sptpc_peer #(
  parameter int DELAY = 3,
  parameter logic [31:0] BAD_REC = 32'h0000_000D,
  parameter logic [31:0] FAIL_CODE = 32'h0000_0002
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Received character stream
  output logic rx_valid,
  output logic [7:0] rx_char,
  // Message sender
  input wire logic msg_send,
  input wire logic [31:0] msg_record,
  output logic msg_done,
  output logic [31:0] msg_status
);
  int cnt;
  logic [31:0] rec;
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
  end
  task automatic send_char(input logic [7:0] c);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_char <= c;
  endtask
  // The character line flips when idle so a stale value is never read as fresh.
  task automatic idle();
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_char <= ~rx_char;
  endtask
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      rec <= '0;
      msg_done <= 1'b0;
      msg_status <= '0;
    end else begin
      msg_done <= (cnt == 1);
      msg_status <= (cnt == 1) ? ((rec == BAD_REC) ? FAIL_CODE : 32'h0000_0000) : ~msg_status;
      if (msg_send) begin
        cnt <= DELAY;
        rec <= msg_record;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/sptpc_test.sv ====
// Self-checking testbench for the serial port control block.
`timescale 1ns/1ps
`default_nettype none
module sptpc_test;
  import sptpc_pkg::*;
  typedef struct packed {
    logic [15:0] num;
    logic [31:0] wdata;
    logic [31:0] exp;
  } sptpc_row_t;
  localparam logic [7:0] ADDR_DEF = 8'h01;
  logic core_clk;
  logic rst_n;
  sptpc_reg_req_t reg_req;
  sptpc_reg_rsp_t reg_rsp;
  sptpc_word_t mb_rd_in;
  sptpc_word_t mb_rd_out;
  sptpc_proto_t proto;
  sptpc_limits_t limits;
  logic rx_valid, slave_addr_en, term_hit, msg_send, msg_done, nv_addr_ok, nv_save;
  logic [7:0] rx_char, port_sel, slave_addr, nv_addr, nv_save_addr;
  logic [31:0] msg_record, msg_status;
  int errors;
  int tests_run;
  sptpc_row_t rows [12] = '{
    '{SPTPC_REG_TERM_CHAR, 32'h3B, 32'h3B}, '{SPTPC_REG_SWAP, 32'h1, 32'h1},
    '{SPTPC_REG_ACT_ADDR, 32'h22, 32'h22}, '{16'h3055, 32'h5, 32'h0},
    '{SPTPC_REG_DONE_LEN, 32'h9, 32'h0}, '{SPTPC_REG_PROTOCOL, 32'h1, 32'h1},
    '{SPTPC_REG_PROTOCOL, 32'h2, 32'h2}, '{SPTPC_REG_PROTOCOL, 32'h4, 32'h4},
    '{SPTPC_REG_PROTOCOL, 32'h7, 32'h7}, '{SPTPC_REG_PROTOCOL, 32'h5, 32'h7},
    '{SPTPC_REG_PROTOCOL, 32'h3, 32'h3}, '{SPTPC_REG_PORT_SEL, 32'h2, 32'h2}};
  sptpc_top #(.ADDR_DEFAULT(ADDR_DEF)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rsp(reg_rsp), .rx_valid(rx_valid), .rx_char(rx_char),
    .mb_rd_in(mb_rd_in), .mb_rd_out(mb_rd_out), .proto(proto), .port_sel(port_sel),
    .slave_addr_en(slave_addr_en), .slave_addr(slave_addr), .limits(limits),
    .term_hit(term_hit), .msg_send(msg_send), .msg_record(msg_record), .msg_done(msg_done),
    .msg_status(msg_status), .nv_addr(nv_addr), .nv_addr_ok(nv_addr_ok), .nv_save(nv_save),
    .nv_save_addr(nv_save_addr));
  sptpc_peer peer (.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_char(rx_char),
    .msg_send(msg_send), .msg_record(msg_record), .msg_done(msg_done), .msg_status(msg_status));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] num, input logic [31:0] data);
    @(posedge core_clk);
    reg_req <= '{1'b1, 1'b0, num, data};
    @(posedge core_clk);
    reg_req <= '0;
  endtask
  // The answer stands one cycle only, so it is taken right after its edge.
  task automatic rd_chk(input logic [15:0] num, input logic [31:0] exp);
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b1, num, 32'h0};
    @(posedge core_clk);
    reg_req <= '0;
    #1;
    cmp({31'h0, reg_rsp.rvalid}, 32'h1);
    cmp(reg_rsp.rdata, exp);
  endtask
  task automatic wait_msg();
    int k;
    k = 0;
    while (msg_done !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (msg_done !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  task automatic send_text(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    peer.send_char(a);
    peer.send_char(b);
    peer.send_char(c);
    peer.idle();
    repeat (3) @(posedge core_clk);
  endtask
  initial begin
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    reg_req = '0;
    mb_rd_in = '0;
    nv_addr = 8'h44;
    nv_addr_ok = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(SPTPC_REG_PROTOCOL, 32'h0);
    rd_chk(SPTPC_REG_TERM_CHAR, {24'h0, SPTPC_TERM_RESET});
    rd_chk(SPTPC_REG_SWAP, 32'h0);
    rd_chk(SPTPC_REG_ACT_ADDR, {24'h0, ADDR_DEF});
    @(posedge core_clk);
    nv_addr_ok <= 1'b1;
    @(posedge core_clk);
    nv_addr_ok <= 1'b0;
    rd_chk(SPTPC_REG_GLB_ADDR, 32'h44);
    rd_chk(SPTPC_REG_ACT_ADDR, 32'h44);
    wr_reg(SPTPC_REG_SAVE, SPTPC_SAVE_CMD);
    #1;
    cmp({23'h0, nv_save, nv_save_addr}, {23'h0, 1'b1, 8'h44});
    for (int i = 0; i < 12; i++) begin
      wr_reg(rows[i].num, rows[i].wdata);
      rd_chk(rows[i].num, rows[i].exp);
    end
    cmp({15'h0, slave_addr_en, port_sel, slave_addr}, {15'h0, 1'b1, 8'h02, 8'h22});
    // Terminator seen with parsing off, then cleared by the host.
    send_text(8'h41, 8'h42, 8'h3B);
    rd_chk(SPTPC_REG_DONE_LEN, 32'h3);
    rd_chk(SPTPC_REG_RX_STATUS, {24'h0, SPTPC_RX_DONE_MARK});
    wr_reg(SPTPC_REG_RX_STATUS, 32'h0);
    rd_chk(SPTPC_REG_DONE_LEN, 32'h0);
    rd_chk(SPTPC_REG_RX_STATUS, 32'h0);
    wr_reg(SPTPC_REG_PARSE_EN, 32'h1);
    send_text(8'h58, 8'h3B, 8'h3B);
    rd_chk(SPTPC_REG_RX_STATUS, 32'h0);
    rd_chk(SPTPC_REG_DONE_LEN, 32'h0);
    // Back-to-back reads at an even and an odd register.
    @(posedge core_clk);
    mb_rd_in <= '{1'b1, 16'h0000, 32'h1111_2222};
    @(posedge core_clk);
    mb_rd_in <= '{1'b1, 16'h0001, 32'h3333_4444};
    #1;
    cmp(mb_rd_out.data, 32'h2222_1111);
    cmp({15'h0, mb_rd_out.valid, mb_rd_out.addr}, 32'h0001_0000);
    @(posedge core_clk);
    mb_rd_in <= '0;
    #1;
    cmp(mb_rd_out.data, 32'h3333_4444);
    cmp({15'h0, mb_rd_out.valid, mb_rd_out.addr}, 32'h0001_0001);
    // With the swap control off an even register must pass unchanged.
    wr_reg(SPTPC_REG_SWAP, 32'h0);
    mb_rd_in <= '{1'b1, 16'h0002, 32'h5555_6666};
    @(posedge core_clk);
    mb_rd_in <= '0;
    #1;
    cmp(mb_rd_out.data, 32'h5555_6666);
    wr_reg(SPTPC_REG_MSG_XFER, 32'h0000_000D);
    wait_msg();
    rd_chk(SPTPC_REG_MSG_XFER, 32'h0000_0002);
    wr_reg(SPTPC_REG_MSG_XFER, 32'h0000_0005);
    wait_msg();
    rd_chk(SPTPC_REG_MSG_XFER, SPTPC_MSG_OK);
    conclude();
  end
endmodule
`default_nettype wire
